//--- include/mpie_consts.vh
`ifndef MPIE_CONSTS_VH
`define MPIE_CONSTS_VH

// register byte offsets, one aligned 32-bit word each
`define MPIE_ADDR_CTRL     5'h00
`define MPIE_ADDR_STAT     5'h04
`define MPIE_ADDR_MGMT     5'h08
`define MPIE_ADDR_TXDAT    5'h0C
`define MPIE_ADDR_RXDAT    5'h10
`define MPIE_ADDR_MDIO     5'h14

// general control field positions
`define MPIE_CTRL_CODEC    0
`define MPIE_CTRL_LOOP     1
`define MPIE_CTRL_VMODE    2
`define MPIE_CTRL_CABLE    3
`define MPIE_CTRL_PORT0    4
`define MPIE_CTRL_PORT1    5
`define MPIE_CTRL_PDN      6
`define MPIE_CTRL_LNKDIS   7
`define MPIE_CTRL_RST      8'h00

// general status field positions
`define MPIE_STAT_COL      0
`define MPIE_STAT_CRS      1
`define MPIE_STAT_RXV      2
`define MPIE_STAT_TXF      3
`define MPIE_STAT_RXOVF    4
`define MPIE_STAT_MDIN     5
`define MPIE_STAT_RXDV     10
`define MPIE_STAT_RXER     11
`define MPIE_STAT_RXD3     12
`define MPIE_STAT_RXD1     13
`define MPIE_STAT_RXD2     15

// management clock divider: half period is field+1 system clocks
`define MPIE_MGMT_RST      4'h4

// transmit / receive data word layout
`define MPIE_DAT_ERR       4
`define MPIE_DAT_VALID     8

// management data line bit-level control
`define MPIE_MDIO_OUT      0
`define MPIE_MDIO_OE       1
`define MPIE_MDIO_RST      2'h0

// index of the last bit of a nibble on the serial codec path
`define MPIE_SER_LAST      2'h3

`endif

//--- logic/mpie_sync.v
`timescale 1ns/1ps
`default_nettype none

module mpie_sync #(
  parameter W = 1
) (
  input  wire         ref_clk_i,
  input  wire         rst_n_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer     k;

  // s1 only feeds s2; a change counts once s2 and s3 agree
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1  <= {W{1'b0}};
      s2  <= {W{1'b0}};
      s3  <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else if (ce_i) begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      for (k = 0; k < W; k = k + 1) begin
        if (s2[k] == s3[k]) begin
          q_o[k] <= s3[k];
        end
      end
    end
  end

endmodule // mpie_sync

`default_nettype wire

//--- logic/mpie_top.v
`timescale 1ns/1ps
`default_nettype none
`include "mpie_consts.vh"

// Function
// - management clock divided per divider field
// - management data line driven by either side
// - transmit pins launched on transmit clock edge
// - normal mode sends four-bit nibbles
// - transmit enable only with valid data
// - transmit error flags erroneous outgoing data
// - receive data sampled on receive clock
// - codec mode transmits on bit zero only
// - codec mode receives on bit zero only
// - codec mode clock pin shows loopback xor vendor
// - codec mode data pin shows cable type
// - codec mode txd3/txd2 show port type bits
// - codec mode txd1 inverted power-down, open collector
// - codec mode error pin shows link test disable
// - rxd3, rxd2, rxd1 read at 12, 15, 13
// - receive error bit 11, valid bit 10
// - outputs from control, inputs in status
module mpie_top (
  input  wire        ref_clk_i,
  input  wire        resetn_i,
  input  wire        ce_i,
  input  wire [4:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  output reg         mdc_o,
  input  wire        mdio_i,
  output reg         mdio_o,
  output reg         mdio_oe_o,
  input  wire        tx_clk_i,
  output reg  [3:0]  txd_o,
  output reg         txd1_oe_o,
  output reg         tx_er_o,
  output reg         tx_en_o,
  input  wire        col_i,
  input  wire        crs_i,
  input  wire        rx_clk_i,
  input  wire [3:0]  rxd_i,
  input  wire        rx_er_i,
  input  wire        rx_dv_i
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  reg        rst_m;
  reg        rst_n;
  wire [9:0] pins_s;
  wire       tx_clk_s;
  wire       rx_clk_s;
  wire [3:0] rxd_s;
  wire       rx_er_s;
  wire       rx_dv_s;
  wire       col_s;
  wire       crs_s;
  wire       mdio_s;
  reg        tx_clk_d;
  reg        rx_clk_d;
  wire       tx_rise;
  wire       rx_rise;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  mpie_sync #(
    .W(10)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i  (rst_n),
    .ce_i     (ce_i),
    .d_i      ({mdio_i, crs_i, col_i, rx_dv_i, rx_er_i, rxd_i, rx_clk_i}),
    .q_o      (pins_s)
  );

  assign rx_clk_s = pins_s[0];
  assign rxd_s    = pins_s[4:1];
  assign rx_er_s  = pins_s[5];
  assign rx_dv_s  = pins_s[6];
  assign col_s    = pins_s[7];
  assign crs_s    = pins_s[8];
  assign mdio_s   = pins_s[9];

  // transmit clock gets its own copy so its edge is never skewed against receive
  mpie_sync #(
    .W(1)
  ) u_sync_tx (
    .ref_clk_i(ref_clk_i),
    .rst_n_i  (rst_n),
    .ce_i     (ce_i),
    .d_i      (tx_clk_i),
    .q_o      (tx_clk_s)
  );

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_clk_d <= 1'b0;
      rx_clk_d <= 1'b0;
    end else if (ce_i) begin
      tx_clk_d <= tx_clk_s;
      rx_clk_d <= rx_clk_s;
    end
  end

  assign tx_rise = tx_clk_s & ~tx_clk_d;
  assign rx_rise = rx_clk_s & ~rx_clk_d;

  ////////////////////////////////////////////////////////////////////////////
  // register file and avalon slave

  reg  [7:0]  ctrl;
  reg  [3:0]  mgmt_div;
  reg  [1:0]  mdio_ctl;
  reg         ack;
  reg  [4:0]  tx_hold;
  reg         tx_full;
  reg  [3:0]  rx_nib;
  reg         rx_err;
  reg         rx_valid;
  reg         rx_ovf;
  wire        codec;
  wire        req;
  wire        wr_tx;
  wire        take;
  wire        rd_rx;
  wire        rx_set;
  reg  [31:0] next_rdata;

  assign codec = ctrl[`MPIE_CTRL_CODEC];
  assign req   = avs_read_i | avs_write_i;
  // a transmit write stalls while the holding register is still full
  assign wr_tx = avs_write_i & (avs_address_i == `MPIE_ADDR_TXDAT) & avs_byteenable_i[0];
  assign take  = req & ~ack & ~(wr_tx & tx_full);
  assign rd_rx = take & avs_read_i & (avs_address_i == `MPIE_ADDR_RXDAT);
  assign avs_waitrequest_o = req & ~ack;

  always @* begin
    next_rdata = 32'h0000_0000;
    case (avs_address_i)
      `MPIE_ADDR_CTRL: begin
        next_rdata[7:0] = ctrl;
      end
      `MPIE_ADDR_STAT: begin
        next_rdata[`MPIE_STAT_COL]   = col_s;
        next_rdata[`MPIE_STAT_CRS]   = crs_s;
        next_rdata[`MPIE_STAT_RXV]   = rx_valid;
        next_rdata[`MPIE_STAT_TXF]   = tx_full;
        next_rdata[`MPIE_STAT_RXOVF] = rx_ovf;
        next_rdata[`MPIE_STAT_MDIN]  = mdio_s;
        if (codec) begin
          next_rdata[`MPIE_STAT_RXD3] = rxd_s[3];
          next_rdata[`MPIE_STAT_RXD2] = rxd_s[2];
          next_rdata[`MPIE_STAT_RXD1] = rxd_s[1];
          next_rdata[`MPIE_STAT_RXER] = rx_er_s;
          next_rdata[`MPIE_STAT_RXDV] = rx_dv_s;
        end
      end
      `MPIE_ADDR_MGMT: begin
        next_rdata[3:0] = mgmt_div;
      end
      `MPIE_ADDR_TXDAT: begin
        next_rdata[4:0] = tx_hold;
        next_rdata[`MPIE_DAT_VALID] = tx_full;
      end
      `MPIE_ADDR_RXDAT: begin
        next_rdata[3:0] = rx_nib;
        next_rdata[`MPIE_DAT_ERR] = rx_err;
        next_rdata[`MPIE_DAT_VALID] = rx_valid;
      end
      `MPIE_ADDR_MDIO: begin
        next_rdata[1:0] = mdio_ctl;
        next_rdata[`MPIE_STAT_MDIN] = mdio_s;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      ctrl           <= `MPIE_CTRL_RST;
      mgmt_div       <= `MPIE_MGMT_RST;
      mdio_ctl       <= `MPIE_MDIO_RST;
    end else if (ce_i) begin
      ack <= take;
      if (take & avs_read_i) begin
        avs_readdata_o <= next_rdata;
      end
      if (take & avs_write_i & avs_byteenable_i[0]) begin
        case (avs_address_i)
          `MPIE_ADDR_CTRL: begin
            ctrl <= avs_writedata_i[7:0];
          end
          `MPIE_ADDR_MGMT: begin
            mgmt_div <= avs_writedata_i[3:0];
          end
          `MPIE_ADDR_MDIO: begin
            mdio_ctl <= avs_writedata_i[1:0];
          end
          default: begin
            mdio_ctl <= mdio_ctl;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // management clock divider

  reg [3:0] mdc_cnt;
  reg       mdc_q;

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mdc_cnt <= 4'h0;
      mdc_q   <= 1'b0;
    end else if (ce_i) begin
      if (mdc_cnt >= mgmt_div) begin
        mdc_cnt <= 4'h0;
        mdc_q   <= ~mdc_q;
      end else begin
        mdc_cnt <= mdc_cnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit path

  reg [3:0] tx_d;
  reg       tx_e;
  reg       tx_r;
  reg [2:0] tx_sh;
  reg [1:0] tx_cnt;

  // software must refill the holding register within one nibble time,
  // otherwise enable drops and the frame ends there
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold <= 5'h00;
      tx_full <= 1'b0;
      tx_d    <= 4'h0;
      tx_e    <= 1'b0;
      tx_r    <= 1'b0;
      tx_sh   <= 3'h0;
      tx_cnt  <= 2'h0;
    end else if (ce_i) begin
      if (take & wr_tx) begin
        tx_hold <= avs_writedata_i[4:0];
        tx_full <= 1'b1;
      end
      if (tx_rise) begin
        if (codec && tx_cnt != 2'h0) begin
          tx_d[0] <= tx_sh[0];
          tx_sh   <= {1'b0, tx_sh[2:1]};
          tx_cnt  <= tx_cnt - 2'h1;
          tx_e    <= 1'b1;
        end else if (tx_full) begin
          tx_full <= 1'b0;
          tx_e    <= 1'b1;
          tx_r    <= tx_hold[`MPIE_DAT_ERR];
          if (codec) begin
            tx_d    <= {3'h0, tx_hold[0]};
            tx_sh   <= tx_hold[3:1];
            tx_cnt  <= `MPIE_SER_LAST;
          end else begin
            tx_d <= tx_hold[3:0];
          end
        end else begin
          tx_e <= 1'b0;
          tx_r <= 1'b0;
          tx_d <= 4'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path

  reg [2:0] rx_sh;
  reg [1:0] rx_cnt;
  reg       rx_get;
  reg [3:0] rx_word;
  reg       rx_werr;

  // nibble mode is framed by data valid, codec mode by carrier sense
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh   <= 3'h0;
      rx_cnt  <= 2'h0;
      rx_get  <= 1'b0;
      rx_word <= 4'h0;
      rx_werr <= 1'b0;
    end else if (ce_i) begin
      rx_get <= 1'b0;
      if (rx_rise) begin
        if (codec) begin
          if (!crs_s) begin
            rx_cnt <= 2'h0;
          end else if (rx_cnt == `MPIE_SER_LAST) begin
            rx_word <= {rxd_s[0], rx_sh};
            rx_werr <= 1'b0;
            rx_get  <= 1'b1;
            rx_cnt  <= 2'h0;
          end else begin
            rx_sh  <= {rxd_s[0], rx_sh[2:1]};
            rx_cnt <= rx_cnt + 2'h1;
          end
        end else if (rx_dv_s) begin
          rx_word <= rxd_s;
          rx_werr <= rx_er_s;
          rx_get  <= 1'b1;
        end
      end
    end
  end

  assign rx_set = rx_get;

  // a nibble landing in the cycle of a clearing read wins over the clear
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_nib   <= 4'h0;
      rx_err   <= 1'b0;
      rx_valid <= 1'b0;
      rx_ovf   <= 1'b0;
    end else if (ce_i) begin
      if (rx_set) begin
        rx_nib   <= rx_word;
        rx_err   <= rx_werr;
        rx_valid <= 1'b1;
        if (rx_valid & ~rd_rx) begin
          rx_ovf <= 1'b1;
        end
      end else if (rd_rx) begin
        rx_valid <= 1'b0;
        rx_ovf   <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin multiplexing, all pins registered

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mdc_o     <= 1'b0;
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
      txd_o     <= 4'h0;
      txd1_oe_o <= 1'b1;
      tx_er_o   <= 1'b0;
      tx_en_o   <= 1'b0;
    end else if (ce_i) begin
      tx_en_o <= tx_e;
      if (codec) begin
        mdc_o     <= ctrl[`MPIE_CTRL_LOOP] ^ ctrl[`MPIE_CTRL_VMODE];
        mdio_o    <= ctrl[`MPIE_CTRL_CABLE];
        mdio_oe_o <= 1'b1;
        txd_o[3]  <= ctrl[`MPIE_CTRL_PORT0];
        txd_o[2]  <= ctrl[`MPIE_CTRL_PORT1];
        // open collector: pull low only when powered down, else release
        txd_o[1]  <= 1'b0;
        txd1_oe_o <= ctrl[`MPIE_CTRL_PDN];
        txd_o[0]  <= tx_d[0];
        tx_er_o   <= ctrl[`MPIE_CTRL_LNKDIS];
      end else begin
        mdc_o     <= mdc_q;
        mdio_o    <= mdio_ctl[`MPIE_MDIO_OUT];
        mdio_oe_o <= mdio_ctl[`MPIE_MDIO_OE];
        txd_o     <= tx_d;
        txd1_oe_o <= 1'b1;
        tx_er_o   <= tx_r;
      end
    end
  end

endmodule // mpie_top

`default_nettype wire

//--- tb/mpie_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpie_consts.vh"
module mpie_properties (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic        ce_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        mdc_o,
  input wire logic        mdio_o,
  input wire logic        mdio_oe_o,
  input wire logic        tx_clk_i,
  input wire logic [3:0]  txd_o,
  input wire logic        txd1_oe_o,
  input wire logic        tx_er_o,
  input wire logic        tx_en_o
);
  logic [7:0] ctrl;
  logic [3:0] div;
  logic [4:0] half;
  logic [3:0] since_tx;
  logic [1:0] armed;
  logic       wr_ok;
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  ////////////////////////////////////////////////////////////
  // shadow taken when the master sees the write complete
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl     <= 8'h00;
      div      <= 4'h4;
      half     <= 5'h00;
      since_tx <= 4'h0;
      armed    <= 2'h0;
    end else begin
      if (wr_ok && avs_address_i == `MPIE_ADDR_CTRL)
        ctrl <= avs_writedata_i[7:0];
      if (wr_ok && avs_address_i == `MPIE_ADDR_MGMT)
        div <= avs_writedata_i[3:0];
      half     <= $changed(mdc_o) ? 5'h01 : half + 5'h01;
      since_tx <= $rose(tx_clk_i) ? 4'h0 : (since_tx == 4'hF ? 4'hF : since_tx + 4'h1);
      // a config write, mode switch or freeze cuts short or stretches a half period: skip two edges
      if (wr_ok && (avs_address_i == `MPIE_ADDR_CTRL || avs_address_i == `MPIE_ADDR_MGMT))
        armed <= 2'h0;
      else if (!ce_i)
        armed <= 2'h0;
      else if ($changed(mdc_o) && armed != 2'h2)
        armed <= armed + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_mdc_edge;
    $changed(mdc_o) && armed == 2'h2 && !ctrl[0];
  endsequence
  sequence s_codec_quiet;
    ctrl[0] && $stable(ctrl);
  endsequence
  AST_MDC_HALF: assert property (s_mdc_edge |-> half == {1'b0, div} + 5'h01)
    else $error("mdc half period wrong");
  AST_TX_PHASE: assert property ($changed(tx_en_o) |-> since_tx inside {[1:8]})
    else $error("tx enable moved off the tx clock");
  AST_CODEC_MDC: assert property (s_codec_quiet |-> mdc_o == (ctrl[1] ^ ctrl[2]))
    else $error("codec mdc pin wrong");
  AST_CODEC_MDIO: assert property (s_codec_quiet |-> mdio_oe_o && mdio_o == ctrl[3])
    else $error("codec mdio pin wrong");
  AST_CODEC_PORT: assert property (s_codec_quiet |-> txd_o[3:2] == {ctrl[4], ctrl[5]})
    else $error("codec port pins wrong");
  AST_CODEC_PDN: assert property (s_codec_quiet |-> txd1_oe_o == ctrl[6] && !txd_o[1])
    else $error("codec power-down pin wrong");
  AST_CODEC_LNK: assert property (s_codec_quiet |-> tx_er_o == ctrl[7])
    else $error("codec link pin wrong");
  AST_NORM_TXD1: assert property (!ctrl[0] && $stable(ctrl) |-> txd1_oe_o)
    else $error("txd1 not driven in normal mode");
endmodule // mpie_properties
bind mpie_top mpie_properties u_props (
  .ref_clk_i, .resetn_i, .ce_i, .avs_address_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_waitrequest_o, .mdc_o, .mdio_o, .mdio_oe_o,
  .tx_clk_i, .txd_o, .txd1_oe_o, .tx_er_o, .tx_en_o
);
`default_nettype wire

//--- tb/mpie_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module mpie_phy_model (
  input  wire logic [3:0] txd_i,
  input  wire logic       tx_en_i,
  input  wire logic       tx_er_i,
  input  wire logic       mdio_i,
  input  wire logic       mdio_oe_i,
  output logic            tx_clk_o,
  output logic            rx_clk_o,
  output logic [3:0]      rxd_o,
  output logic            rx_er_o,
  output logic            rx_dv_o,
  output logic            crs_o,
  output logic            col_o,
  output wire logic       mdio_o
);
  logic [4:0] tx_log [0:7];
  int         tx_n = 0;
  // pad pull-up; this side only listens in bit-bang use
  assign mdio_o = mdio_oe_i ? mdio_i : 1'b1;
  initial begin
    rx_clk_o = 1'b0;
    rxd_o    = 4'h0;
    rx_er_o  = 1'b0;
    rx_dv_o  = 1'b0;
    crs_o    = 1'b0;
    col_o    = 1'b0;
    tx_clk_o = 1'b0;
    forever #40 tx_clk_o = ~tx_clk_o;
  end
  // sampled a full period after launch, covering the device's sync lag
  always @(posedge tx_clk_o) begin
    if (tx_en_i === 1'b1 && tx_n < 8) begin
      tx_log[tx_n] <= {tx_er_i, txd_i};
      tx_n         <= tx_n + 1;
    end
  end
  task automatic beat(input logic [3:0] d, input logic er, input logic dv, input logic cs, input int hp);
    rxd_o   = d;
    rx_er_o = er;
    rx_dv_o = dv;
    crs_o   = cs;
    #hp;
    rx_clk_o = 1'b1;
    #hp;
    rx_clk_o = 1'b0;
  endtask
  task automatic collide(input logic c);
    col_o = c;
  endtask
  // data lines flip while the qualifiers drop, so a stale value cannot pass
  task automatic idle();
    rx_dv_o = 1'b0;
    rx_er_o = 1'b0;
    crs_o   = 1'b0;
    rxd_o   = ~rxd_o;
  endtask
endmodule // mpie_phy_model
`default_nettype wire

//--- tb/mii_pin_interface_serial_codec_mode_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpie_consts.vh"
module mii_pin_interface_serial_codec_mode_test;
  logic        ref_clk_i, resetn_i, ce_i, avs_read_i, avs_write_i;
  logic [4:0]  avs_address_i;
  logic [31:0] avs_writedata_i, q;
  logic [3:0]  avs_byteenable_i, nib;
  wire  [31:0] avs_readdata_o;
  wire  [3:0]  txd_o, rxd_i;
  wire         avs_waitrequest_o, mdc_o, mdio_i, mdio_o, mdio_oe_o, tx_clk_i, txd1_oe_o;
  wire         tx_er_o, tx_en_o, col_i, crs_i, rx_clk_i, rx_er_i, rx_dv_i;
  int          err_count = 0;
  int          n_checks = 0;
  // control byte, then expected mdc, mdio, txd3, txd2, txd1 enable, tx error
  logic [15:0] rows [0:8] = '{16'h0100, 16'h0320, 16'h0520, 16'h0700, 16'h0910,
                              16'h1108, 16'h2104, 16'h4102, 16'h8101};
  mpie_top uut (.ref_clk_i, .resetn_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .mdc_o, .mdio_i,
    .mdio_o, .mdio_oe_o, .tx_clk_i, .txd_o, .txd1_oe_o, .tx_er_o, .tx_en_o, .col_i, .crs_i,
    .rx_clk_i, .rxd_i, .rx_er_i, .rx_dv_i);
  mpie_phy_model phy (.txd_i(txd_o), .tx_en_i(tx_en_o), .tx_er_i(tx_er_o), .mdio_i(mdio_o),
    .mdio_oe_i(mdio_oe_o), .tx_clk_o(tx_clk_i), .rx_clk_o(rx_clk_i), .rxd_o(rxd_i),
    .rx_er_o(rx_er_i), .rx_dv_o(rx_dv_i), .crs_o(crs_i), .col_o(col_i), .mdio_o(mdio_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n > 400) begin
      err_count++;
      $display("BAD t=%0t wait ran out got=%h exp=%h", $time, n, 400);
      summarize();
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      guard(n);
      @(posedge ref_clk_i);
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(q & m, e);
  endtask
  task automatic wait_tx(input int k);
    int n;
    n = 0;
    while (phy.tx_n < k) begin
      n++;
      guard(n);
      @(posedge ref_clk_i);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    resetn_i         = 1'b0;
    ce_i             = 1'b1;
    avs_address_i    = 5'h00;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h00000000;
    avs_byteenable_i = 4'hF;
    nib              = 4'h6;
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd(`MPIE_ADDR_CTRL, 32'hFFFFFFFF, 32'h00000000);
    rd(`MPIE_ADDR_MGMT, 32'h0000000F, 32'h00000004);
    wr(5'h18, 32'h000000FF);
    rd(5'h18, 32'hFFFFFFFF, 32'h00000000);
    $display("reset test done");
    for (int i = 0; i < 9; i++) begin
      wr(`MPIE_ADDR_CTRL, {24'h000000, rows[i][15:8]});
      @(posedge ref_clk_i);
      q = 32'({mdc_o, mdio_o, txd_o[3:2], txd1_oe_o, tx_er_o, mdio_oe_o, txd_o[1]});
      chk(q, 32'({rows[i][5:0], 2'b10}));
    end
    $display("codec output test done");
    wr(`MPIE_ADDR_CTRL, 32'h00000001);
    phy.beat(4'hA, 1'b1, 1'b0, 1'b0, 40);
    rd(`MPIE_ADDR_STAT, 32'h0000BC00, 32'h00003800);
    phy.beat(4'h4, 1'b0, 1'b1, 1'b0, 40);
    rd(`MPIE_ADDR_STAT, 32'h0000BC00, 32'h00008400);
    wr(`MPIE_ADDR_CTRL, 32'h00000000);
    rd(`MPIE_ADDR_STAT, 32'h0000BC00, 32'h00000000);
    $display("codec input test done");
    phy.tx_n = 0;
    wr(`MPIE_ADDR_TXDAT, 32'h0000001A);
    wr(`MPIE_ADDR_TXDAT, 32'h00000005);
    wait_tx(2);
    chk(32'(phy.tx_log[0]), 32'h0000001A);
    chk(32'(phy.tx_log[1]), 32'h00000005);
    repeat (40) @(posedge ref_clk_i);
    chk(32'({tx_en_o, 4'(phy.tx_n)}), 32'h00000002);
    wr(`MPIE_ADDR_CTRL, 32'h00000001);
    phy.tx_n = 0;
    wr(`MPIE_ADDR_TXDAT, 32'h00000009);
    wait_tx(4);
    chk(32'({phy.tx_log[3][0], phy.tx_log[2][0], phy.tx_log[1][0], phy.tx_log[0][0]}), 32'h00000009);
    $display("transmit test done");
    for (int i = 0; i < 4; i++)
      phy.beat({3'h5, nib[i]}, 1'b0, 1'b0, 1'b1, 60);
    phy.idle();
    rd(`MPIE_ADDR_RXDAT, 32'h0000011F, 32'h00000106);
    wr(`MPIE_ADDR_CTRL, 32'h00000000);
    phy.beat(4'hC, 1'b1, 1'b1, 1'b1, 60);
    phy.idle();
    rd(`MPIE_ADDR_RXDAT, 32'h0000011F, 32'h0000011C);
    rd(`MPIE_ADDR_RXDAT, 32'h00000100, 32'h00000000);
    phy.collide(1'b1);
    repeat (6) @(posedge ref_clk_i);
    rd(`MPIE_ADDR_STAT, 32'h00000003, 32'h00000001);
    phy.collide(1'b0);
    $display("receive test done");
    wr(`MPIE_ADDR_MDIO, 32'h00000002);
    repeat (4) @(posedge ref_clk_i);
    rd(`MPIE_ADDR_MDIO, 32'h00000023, 32'h00000002);
    wr(`MPIE_ADDR_MDIO, 32'h00000000);
    repeat (4) @(posedge ref_clk_i);
    rd(`MPIE_ADDR_MDIO, 32'h00000023, 32'h00000020);
    wr(`MPIE_ADDR_MGMT, 32'h00000000);
    repeat (20) @(posedge ref_clk_i);
    ce_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    q = 32'(mdc_o);
    repeat (10) @(posedge ref_clk_i);
    chk(32'(mdc_o), q);
    ce_i <= 1'b1;
    wr(`MPIE_ADDR_MGMT, 32'h0000000F);
    repeat (80) @(posedge ref_clk_i);
    $display("management test done");
    summarize();
  end
endmodule // mii_pin_interface_serial_codec_mode_test
`default_nettype wire
